/* File: pkg/qdc_consts.svh */
// constants of the quadrature distance counter: offsets, fields, codes, resets, timing
// assumes inclusion by bare name from the package and the design files
`ifndef QDC_CONSTS_SVH
`define QDC_CONSTS_SVH

// ============================================================
// counter width
`define QDC_CNT_W 30

// ============================================================
// register byte offsets (haddr[7:0])
`define QDC_ADDR_CMD 8'h00
`define QDC_ADDR_REPLY 8'h04
`define QDC_ADDR_STATUS 8'h08
`define QDC_ADDR_COUNT 8'h0C
`define QDC_ADDR_RATE 8'h10
`define QDC_ADDR_SLAVES 8'h14
`define QDC_ADDR_CTRL 8'h18

// ============================================================
// field positions
`define QDC_ST_READY 0
`define QDC_ST_SLAVE_OK 1
`define QDC_ST_FAIL 2
`define QDC_ST_BUSY 3
`define QDC_REPLY_VALID 8
`define QDC_CTRL_FACTORY 0
`define QDC_CTRL_RESTART 1
`define QDC_SLAVE2_BIT 1

// ============================================================
// characters of the command link
`define QDC_CH_ESC 8'h1B
`define QDC_CH_LBRACK 8'h5B
`define QDC_CH_SEMI 8'h3B
`define QDC_CH_PIPE 8'h7C
`define QDC_CH_CFG 8'h76
`define QDC_CH_LESS 8'h3C
`define QDC_CH_PLUS 8'h2B
`define QDC_CH_MINUS 8'h2D
`define QDC_CH_LF 8'h0A
`define QDC_CH_ZERO 8'h30
`define QDC_CH_NINE 8'h39

// ============================================================
// command parameters and configuration items
`define QDC_CMD_QUERY 32'h00000064
`define QDC_CMD_PRESET 32'h00000065
`define QDC_ITEM_SLAVES 32'h0000003A
`define QDC_ITEM_RATE 32'h00000028
`define QDC_ITEM_SAVE 32'h00000001

// ============================================================
// reset values
`define QDC_RATE_DEFAULT 24'h002580
`define QDC_SLAVES_FACTORY 8'h0A
`define QDC_SLAVES_DEFAULT 8'h00

// ============================================================
// timing
`define QDC_CLK_PERIOD_NS 25
`define QDC_BOOT_READY_NS 100000
`define QDC_BOOT_READY_CYC ((`QDC_BOOT_READY_NS + `QDC_CLK_PERIOD_NS - 1) / `QDC_CLK_PERIOD_NS)
`define QDC_BOOT_W 12

`endif

/* File: pkg/qdc_pkg.sv */
// types of the quadrature distance counter
// assumes qdc_consts.svh on the include path
`include "qdc_consts.svh"

package qdc_pkg;

    // ============================================================
    // state enumerations
    typedef enum logic [1:0] {PS_IDLE, PS_BRACKET, PS_PARAM} qdc_pstate_t;
    typedef enum logic [1:0] {FS_IDLE, FS_DIGIT, FS_LF} qdc_fstate_t;

    // ============================================================
    // carriers between modules
    typedef struct packed {
        logic signed [`QDC_CNT_W-1:0] count;
        logic lamp_a;
        logic lamp_b;
    } qdc_enc_stat_t;

    typedef struct packed {
        logic load;
        logic signed [`QDC_CNT_W-1:0] value;
    } qdc_preset_t;

    typedef struct packed {
        logic valid;
        logic [7:0] ch;
    } qdc_char_t;

    // ============================================================
    // module states
    typedef struct packed {
        qdc_fstate_t state;
        logic [`QDC_CNT_W-1:0] mag;
        logic [3:0] idx;
        logic [3:0] digit;
        logic started;
        qdc_char_t out;
    } qdc_fmt_state_t;

    typedef struct packed {
        qdc_pstate_t pstate;
        logic [31:0] p0;
        logic [31:0] p1;
        logic in_p1;
        logic has_p1;
        logic neg;
        logic [7:0] pend_slaves;
        logic [7:0] saved_slaves;
        logic [7:0] act_slaves;
        logic [23:0] pend_rate;
        logic [23:0] saved_rate;
        logic [23:0] act_rate;
        logic [`QDC_BOOT_W-1:0] boot_cnt;
        logic ready;
        logic fail;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        qdc_preset_t preset;
        logic fmt_start;
    } qdc_top_state_t;

endpackage

/* File: verilog/qdc_quad_decoder.sv */
// quadrature decoder: up/down position count and channel level lamps
// assumes encoder levels synchronous to core_clk_i
`include "qdc_consts.svh"

module qdc_quad_decoder (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // encoder channels
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    // preset from the command side
    input wire qdc_pkg::qdc_preset_t preset_i,
    // count and lamps
    output qdc_pkg::qdc_enc_stat_t stat_o
);

    qdc_pkg::qdc_enc_stat_t st;
    qdc_pkg::qdc_enc_stat_t next_st;

    // ============================================================
    // decode
    always_comb begin
        next_st = st;
        next_st.lamp_a = enc_a_i;
        next_st.lamp_b = enc_b_i;
        case ({st.lamp_a, st.lamp_b, enc_a_i, enc_b_i})
            4'h2, 4'hB, 4'hD, 4'h4: begin
                next_st.count = st.count + `QDC_CNT_W'sh1;
            end
            4'h1, 4'h7, 4'hE, 4'h8: begin
                next_st.count = st.count - `QDC_CNT_W'sh1;
            end
            default: begin
                next_st.count = st.count;
            end
        endcase
        if (preset_i.load) begin
            next_st.count = preset_i.value;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign stat_o = st;

endmodule

/* File: verilog/qdc_dec_formatter.sv */
// formatter: signed count to sign, decimal digits and line feed, one char at a time
// assumes the consumer pops a char by raising ready_i while valid is shown
`include "qdc_consts.svh"

module qdc_dec_formatter (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // request
    input wire logic start_i,
    input wire logic signed [`QDC_CNT_W-1:0] value_i,
    // characters out
    input wire logic ready_i,
    output qdc_pkg::qdc_char_t char_o,
    output logic busy_o
);

    qdc_pkg::qdc_fmt_state_t st;
    qdc_pkg::qdc_fmt_state_t next_st;

    function automatic logic [`QDC_CNT_W-1:0] pow10(input logic [3:0] idx);
        case (idx)
            4'h9: pow10 = 30'h3B9ACA00;
            4'h8: pow10 = 30'h05F5E100;
            4'h7: pow10 = 30'h00989680;
            4'h6: pow10 = 30'h000F4240;
            4'h5: pow10 = 30'h000186A0;
            4'h4: pow10 = 30'h00002710;
            4'h3: pow10 = 30'h000003E8;
            4'h2: pow10 = 30'h00000064;
            4'h1: pow10 = 30'h0000000A;
            default: pow10 = 30'h00000001;
        endcase
    endfunction

    // ============================================================
    // digit extraction by repeated subtraction
    always_comb begin
        next_st = st;
        if (st.out.valid && ready_i) begin
            next_st.out.valid = 1'b0;
        end
        case (st.state)
            qdc_pkg::FS_IDLE: begin
                if (start_i) begin
                    next_st.mag = value_i[`QDC_CNT_W-1] ? `QDC_CNT_W'(-value_i) : `QDC_CNT_W'(value_i);
                    next_st.out.valid = 1'b1;
                    next_st.out.ch = value_i[`QDC_CNT_W-1] ? `QDC_CH_MINUS : `QDC_CH_PLUS;
                    next_st.idx = 4'h9;
                    next_st.digit = 4'h0;
                    next_st.started = 1'b0;
                    next_st.state = qdc_pkg::FS_DIGIT;
                end
            end
            qdc_pkg::FS_DIGIT: begin
                if (st.mag >= pow10(st.idx)) begin
                    next_st.mag = st.mag - pow10(st.idx);
                    next_st.digit = st.digit + 4'h1;
                end else if (!st.out.valid) begin
                    if (st.digit != 4'h0 || st.started || st.idx == 4'h0) begin
                        next_st.out.valid = 1'b1;
                        next_st.out.ch = `QDC_CH_ZERO + {4'h0, st.digit};
                        next_st.started = 1'b1;
                    end
                    next_st.digit = 4'h0;
                    if (st.idx == 4'h0) begin
                        next_st.state = qdc_pkg::FS_LF;
                    end else begin
                        next_st.idx = st.idx - 4'h1;
                    end
                end
            end
            qdc_pkg::FS_LF: begin
                if (!st.out.valid) begin
                    next_st.out.valid = 1'b1;
                    next_st.out.ch = `QDC_CH_LF;
                    next_st.state = qdc_pkg::FS_IDLE;
                end
            end
            default: begin
                next_st.state = qdc_pkg::FS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign char_o = st.out;
    assign busy_o = (st.state != qdc_pkg::FS_IDLE) || st.out.valid;

endmodule

/* File: verilog/qdc_top.sv */
// quadrature distance counter: ahb-lite slave, command parser, configuration, counter
// assumes a single ahb-lite master, word transfers, encoder levels synchronous to core_clk_i
//
// Function
// - count is signed 30-bit, -536870912 to +536870911, wrapping.
// - every single-channel A/B transition is counted, well above 200000 per second; a step changing both channels at once is not.
// - command 100 with pipe final sends the current count.
// - reply is decimal text led by plus or minus sign.
// - command 101 with pipe final loads the second parameter.
// - preset without a value loads zero.
// - query and preset fail unless counter slave 2 is enabled.
// - factory restore disables every slave, the counter slave too.
// - saved configuration only takes effect at the next start.
// - link rate comes from item 40, default 9600 bps.
// - two lamps follow the live levels of channels A and B.
`include "qdc_consts.svh"

module qdc_top #(
    parameter int BOOT_CYCLES = `QDC_BOOT_READY_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // encoder
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    // lamps and link rate
    output logic channel_a_level_lamp_o,
    output logic channel_b_level_lamp_o,
    output logic [23:0] link_rate_o
);

    qdc_pkg::qdc_top_state_t st;
    qdc_pkg::qdc_top_state_t next_st;
    qdc_pkg::qdc_enc_stat_t enc_stat;
    qdc_pkg::qdc_char_t fmt_char;
    logic fmt_busy;
    logic reply_pop;

    localparam logic [`QDC_BOOT_W-1:0] BOOT_LAST = `QDC_BOOT_W'(BOOT_CYCLES - 1);

    // ============================================================
    // counter and formatter
    // preset pulse wins over counting
    qdc_quad_decoder u_decoder (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .enc_a_i(enc_a_i),
        .enc_b_i(enc_b_i),
        .preset_i(st.preset),
        .stat_o(enc_stat)
    );

    // reply built from the live count
    qdc_dec_formatter u_formatter (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .start_i(st.fmt_start),
        .value_i(enc_stat.count),
        .ready_i(reply_pop),
        .char_o(fmt_char),
        .busy_o(fmt_busy)
    );

    // ============================================================
    // next state
    // bus decode helpers
    logic addr_ph;
    logic slave_ok;
    logic set_fail;
    logic [7:0] ch;
    logic [31:0] rdata;

    // taken while the bus is ready
    assign addr_ph = hsel_i && hready_i && htrans_i[1];

    assign slave_ok = st.ready && st.act_slaves[`QDC_SLAVE2_BIT];

    // pop only a shown char
    assign reply_pop = addr_ph && !hwrite_i && (haddr_i[7:0] == `QDC_ADDR_REPLY) && fmt_char.valid;

    always_comb begin
        next_st = st;
        set_fail = 1'b0;
        ch = hwdata_i[7:0];
        rdata = 32'h00000000;

        // single-cycle pulses and the fixed okay response
        next_st.preset.load = 1'b0;
        next_st.fmt_start = 1'b0;
        next_st.hreadyout = 1'b1;
        next_st.hresp = 1'b0;

        if (!st.ready) begin
            if (st.boot_cnt == BOOT_LAST) begin
                next_st.ready = 1'b1;
            end else begin
                next_st.boot_cnt = st.boot_cnt + `QDC_BOOT_W'h1;
            end
        end

        // address phase
        // write data lands a cycle later
        next_st.wr_pend = addr_ph && hwrite_i;
        if (addr_ph) begin
            next_st.wr_addr = haddr_i[7:0];
        end

        if (addr_ph && !hwrite_i) begin
            case (haddr_i[7:0])
                `QDC_ADDR_REPLY: begin
                    rdata = {23'h000000, fmt_char.valid, fmt_char.ch};
                end
                `QDC_ADDR_STATUS: begin
                    rdata = {28'h0000000, fmt_busy, st.fail, slave_ok, st.ready};
                end
                `QDC_ADDR_COUNT: begin
                    rdata = {{(32 - `QDC_CNT_W){enc_stat.count[`QDC_CNT_W-1]}}, enc_stat.count};
                end
                `QDC_ADDR_RATE: begin
                    rdata = {8'h00, st.act_rate};
                end
                `QDC_ADDR_SLAVES: begin
                    rdata = {24'h000000, st.act_slaves};
                end
                default: begin
                    rdata = 32'h00000000;
                end
            endcase
            // held until the next read
            next_st.hrdata = rdata;
        end

        // data phase of a write
        if (st.wr_pend) begin
            case (st.wr_addr)
                `QDC_ADDR_STATUS: begin
                    if (hwdata_i[`QDC_ST_FAIL]) begin
                        next_st.fail = 1'b0;
                    end
                end

                `QDC_ADDR_CTRL: begin
                    if (hwdata_i[`QDC_CTRL_FACTORY]) begin
                        next_st.pend_slaves = `QDC_SLAVES_DEFAULT;
                        next_st.saved_slaves = `QDC_SLAVES_DEFAULT;
                        next_st.pend_rate = `QDC_RATE_DEFAULT;
                        next_st.saved_rate = `QDC_RATE_DEFAULT;
                    end

                    // saved set applied only at restart
                    if (hwdata_i[`QDC_CTRL_RESTART]) begin
                        next_st.act_slaves = next_st.saved_slaves;
                        next_st.act_rate = next_st.saved_rate;
                    end
                end

                `QDC_ADDR_CMD: begin
                    case (st.pstate)
                        qdc_pkg::PS_IDLE: begin
                            if (ch == `QDC_CH_ESC) begin
                                next_st.pstate = qdc_pkg::PS_BRACKET;
                            end
                        end

                        qdc_pkg::PS_BRACKET: begin
                            next_st.p0 = 32'h00000000;
                            next_st.p1 = 32'h00000000;
                            next_st.in_p1 = 1'b0;
                            next_st.has_p1 = 1'b0;
                            next_st.neg = 1'b0;
                            next_st.pstate = (ch == `QDC_CH_LBRACK) ? qdc_pkg::PS_PARAM : qdc_pkg::PS_IDLE;
                        end

                        qdc_pkg::PS_PARAM: begin
                            next_st.pstate = qdc_pkg::PS_IDLE;
                            if (ch >= `QDC_CH_ZERO && ch <= `QDC_CH_NINE) begin
                                next_st.pstate = qdc_pkg::PS_PARAM;
                                if (st.in_p1) begin
                                    next_st.p1 = 32'((st.p1 << 3) + (st.p1 << 1) + {28'h0000000, ch[3:0]});
                                    next_st.has_p1 = 1'b1;
                                end else begin
                                    next_st.p0 = 32'((st.p0 << 3) + (st.p0 << 1) + {28'h0000000, ch[3:0]});
                                end
                            end else if (ch == `QDC_CH_SEMI) begin
                                next_st.pstate = qdc_pkg::PS_PARAM;
                                next_st.in_p1 = 1'b1;
                            end else if (ch == `QDC_CH_LESS) begin
                                next_st.pstate = qdc_pkg::PS_PARAM;
                                next_st.neg = st.in_p1 ? 1'b1 : st.neg;
                            end else if (ch == `QDC_CH_ESC) begin
                                next_st.pstate = qdc_pkg::PS_BRACKET;
                            end else if (ch == `QDC_CH_PIPE) begin
                                if (st.p0 == `QDC_CMD_QUERY) begin
                                    if (slave_ok && !fmt_busy) begin
                                        next_st.fmt_start = 1'b1;
                                    end else begin
                                        set_fail = 1'b1;
                                    end
                                end else if (st.p0 == `QDC_CMD_PRESET) begin
                                    if (slave_ok) begin
                                        next_st.preset.load = 1'b1;
                                        if (!st.has_p1) begin
                                            next_st.preset.value = '0;
                                        end else if (st.neg) begin
                                            next_st.preset.value = -$signed(st.p1[`QDC_CNT_W-1:0]);
                                        end else begin
                                            next_st.preset.value = $signed(st.p1[`QDC_CNT_W-1:0]);
                                        end
                                    end else begin
                                        set_fail = 1'b1;
                                    end
                                end else begin
                                    set_fail = 1'b1;
                                end
                            end else if (ch == `QDC_CH_CFG) begin
                                // item 58 then save item 1
                                if (st.p0 == `QDC_ITEM_SLAVES) begin
                                    next_st.pend_slaves = st.p1[7:0];
                                end else if (st.p0 == `QDC_ITEM_RATE) begin
                                    next_st.pend_rate = (st.p1[23:0] == 24'h000000) ? `QDC_RATE_DEFAULT : st.p1[23:0];
                                end else if (st.p0 == `QDC_ITEM_SAVE) begin
                                    next_st.saved_slaves = st.pend_slaves;
                                    next_st.saved_rate = st.pend_rate;
                                end
                            end
                        end

                        default: begin
                            next_st.pstate = qdc_pkg::PS_IDLE;
                        end
                    endcase
                end

                default: begin
                    next_st.fail = next_st.fail;
                end
            endcase
        end

        // set wins over a clear in the same cycle
        if (set_fail) begin
            next_st.fail = 1'b1;
        end
    end

    // ============================================================
    // state register
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            // reset acts as power-up
            st <= '0;
            st.hreadyout <= 1'b1;

            st.pend_slaves <= `QDC_SLAVES_FACTORY;
            st.saved_slaves <= `QDC_SLAVES_FACTORY;
            st.act_slaves <= `QDC_SLAVES_FACTORY;
            st.pend_rate <= `QDC_RATE_DEFAULT;
            st.saved_rate <= `QDC_RATE_DEFAULT;
            st.act_rate <= `QDC_RATE_DEFAULT;
        end else begin
            st <= next_st;
        end
    end

    // ============================================================
    // outputs
    assign hrdata_o = st.hrdata;
    assign hreadyout_o = st.hreadyout;
    assign hresp_o = st.hresp;

    assign channel_a_level_lamp_o = enc_stat.lamp_a;
    assign channel_b_level_lamp_o = enc_stat.lamp_b;

    // active rate moves only on restart
    assign link_rate_o = st.act_rate;

endmodule

/* File: bench/qdc_checker.sv */
// checker of the quadrature distance counter top ports
// assumes bind onto qdc_top, word transfers on the ahb-lite side
`include "qdc_consts.svh"

module qdc_checker #(
    parameter int BOOT_CYCLES = 64
) (
    // clock, reset, bus
    input wire logic core_clk_i, input wire logic rstn_i, input wire logic hsel_i,
    input wire logic [31:0] haddr_i, input wire logic [1:0] htrans_i, input wire logic hwrite_i,
    input wire logic hready_i, input wire logic [31:0] hwdata_i, input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o, input wire logic hresp_o,
    // encoder, lamps, rate
    input wire logic enc_a_i, input wire logic enc_b_i, input wire logic channel_a_level_lamp_o,
    input wire logic channel_b_level_lamp_o, input wire logic [23:0] link_rate_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // ========
    // data-phase tracking
    logic rd_ph;
    logic wr_ctrl;
    logic [7:0] rd_a;
    int cyc;
    always_ff @(posedge core_clk_i) begin
        rd_ph <= rstn_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i;
        wr_ctrl <= rstn_i && hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == `QDC_ADDR_CTRL;
        rd_a <= haddr_i[7:0];
        cyc <= !rstn_i ? 0 : (cyc < 100000 ? cyc + 1 : cyc);
    end
    // ========
    // assertions
    AST_LAMP_A: assert property ($past(rstn_i) |-> channel_a_level_lamp_o == $past(enc_a_i))
        else $error("lamp a does not follow channel a");
    AST_LAMP_B: assert property ($rose(enc_b_i) |=> channel_b_level_lamp_o)
        else $error("lamp b not lit after channel b rose");
    AST_RATE_RST: assert property (!$past(rstn_i) |-> link_rate_o == `QDC_RATE_DEFAULT)
        else $error("link rate not default after reset");
    AST_RATE_HOLD: assert property ($changed(link_rate_o) |-> $past(wr_ctrl && hwdata_i[`QDC_CTRL_RESTART]))
        else $error("link rate changed without restart");
    AST_BUS_OK: assert property ($past(rstn_i) |-> hreadyout_o && !hresp_o)
        else $error("bus response not ready okay");
    AST_COUNT_SIGN: assert property (rd_ph && rd_a == `QDC_ADDR_COUNT |-> hrdata_o[31:30] == {2{hrdata_o[29]}})
        else $error("count read not sign extended");
    AST_ZERO_READ: assert property (rd_ph && (rd_a == `QDC_ADDR_CTRL || rd_a > 8'h18) |-> hrdata_o == 32'h0)
        else $error("write-only or unmapped read not zero");
    AST_SLAVE_OK: assert property (rd_ph && rd_a == `QDC_ADDR_STATUS && hrdata_o[1] |-> hrdata_o[0])
        else $error("slave ok shown while not ready");
    AST_BOOT: assert property (rd_ph && rd_a == `QDC_ADDR_STATUS && cyc + 2 < BOOT_CYCLES |-> !hrdata_o[0])
        else $error("ready shown too early after boot");
endmodule

bind qdc_top qdc_checker #(.BOOT_CYCLES(BOOT_CYCLES)) u_qdc_checker (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .enc_a_i(enc_a_i),
    .enc_b_i(enc_b_i), .channel_a_level_lamp_o(channel_a_level_lamp_o),
    .channel_b_level_lamp_o(channel_b_level_lamp_o), .link_rate_o(link_rate_o));

/* File: bench/qdc_enc_model.sv */
// encoder partner: two channels in gray order, or a jump of two phases on dbl_i, one request per step
// assumes requests change right after a rising edge
module qdc_enc_model (
    // requests
    input wire logic clk_i,
    input wire logic step_i,
    input wire logic up_i,
    input wire logic dbl_i,
    // channels
    output logic a_o,
    output logic b_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] ph = 2'h0;
    always @(posedge clk_i) begin
        if (step_i) begin
            ph <= ph + (dbl_i ? 2'h2 : (up_i ? 2'h1 : 2'h3));
        end
    end
    assign a_o = ph[1] ^ ph[0];
    assign b_o = ph[1];
endmodule

/* File: bench/qdc_top_test.sv */
// self-checking bench of the quadrature distance counter
// assumes the design, checker and encoder model compiled before it
`include "qdc_consts.svh"

module qdc_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, step = 0, up = 0, dbl = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
    logic [1:0] htrans = 0;
    logic hready, hresp, enc_a, enc_b, lamp_a, lamp_b;
    logic [23:0] rate;
    int bad_count = 0, compares = 0, cnt = 0;
    qdc_top #(.BOOT_CYCLES(64)) u_qdc_top (.core_clk_i(clk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .enc_a_i(enc_a), .enc_b_i(enc_b),
        .channel_a_level_lamp_o(lamp_a), .channel_b_level_lamp_o(lamp_b), .link_rate_o(rate));
    qdc_enc_model u_qdc_enc_model (.clk_i(clk), .step_i(step), .up_i(up), .dbl_i(dbl), .a_o(enc_a), .b_o(enc_b));
    initial forever #12.5 clk = ~clk;
    // ========
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        d = hrdata;
    endtask
    task automatic cmd(input string s);
        bus(1, `QDC_ADDR_CMD, 32'h1B);
        bus(1, `QDC_ADDR_CMD, 32'h5B);
        for (int i = 0; i < s.len(); i++) bus(1, `QDC_ADDR_CMD, {24'h0, s[i]});
    endtask
    function automatic int wrap(input int x);
        logic [29:0] t;
        t = x[29:0];
        return $signed(t);
    endfunction
    task automatic rdc();
        repeat (3) @(posedge clk);
        bus(0, `QDC_ADDR_COUNT, 0);
        chk(d, cnt);
    endtask
    task automatic query();
        string e;
        int n;
        e = cnt < 0 ? $sformatf("-%0d\n", -cnt) : $sformatf("+%0d\n", cnt);
        cmd("100|");
        for (int i = 0; i < e.len(); i++) begin
            n = 0;
            do begin bus(0, `QDC_ADDR_REPLY, 0); n++; end while (d[8] !== 1'b1 && n < 50);
            chk({23'h0, d[8:0]}, {24'h1, e[i]});
        end
    endtask
    task automatic preset(input int v);
        cmd(v < 0 ? $sformatf("101;<%0d|", -v) : $sformatf("101;%0d|", v));
        cnt = v;
        rdc();
    endtask
    task automatic mv(input logic u, input logic b);
        step <= 1; up <= u; dbl <= b;
        @(posedge clk);
        step <= 0;
        if (!b) cnt = wrap(cnt + (u ? 1 : -1));
    endtask
    task automatic report_and_stop();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ========
    // sequence and watchdog
    initial begin
        d = $urandom(93069);
        repeat (8) @(posedge clk);
        rstn <= 1;
        cmd("100|");
        bus(0, `QDC_ADDR_STATUS, 0);
        chk(d & 32'h5, 32'h4);
        bus(1, `QDC_ADDR_STATUS, 32'h4);
        repeat (64) @(posedge clk);
        bus(0, `QDC_ADDR_RATE, 0);
        chk(d, 32'h2580);
        bus(0, 8'h40, 0);
        preset(-536870912);
        mv(0, 0);
        rdc();
        query();
        cmd("101|");
        cnt = 0;
        rdc();
        repeat (40) begin mv(1'($urandom_range(1)), $urandom_range(9) == 0); rdc(); end
        query();
        repeat (4) begin preset($urandom_range(1000000) - 500000); query(); end
        bus(1, `QDC_ADDR_CTRL, 32'h1);
        bus(0, `QDC_ADDR_SLAVES, 0);
        chk(d, 32'hA);
        bus(1, `QDC_ADDR_CTRL, 32'h2);
        bus(0, `QDC_ADDR_SLAVES, 0);
        chk(d, 32'h0);
        cmd("100|");
        bus(0, `QDC_ADDR_STATUS, 0);
        chk(d & 32'h6, 32'h4);
        bus(1, `QDC_ADDR_STATUS, 32'h4);
        cmd("58;10v");
        cmd("40;38400v");
        cmd("1v");
        bus(0, `QDC_ADDR_RATE, 0);
        chk(d, 32'h2580);
        bus(1, `QDC_ADDR_CTRL, 32'h2);
        bus(0, `QDC_ADDR_SLAVES, 0);
        chk(d, 32'hA);
        chk({8'h0, rate}, 32'h9600);
        query();
        report_and_stop();
    end
    initial begin
        #(25 * 40000);
        bad_count++;
        report_and_stop();
    end
endmodule
